// File: idt_pkg.sv
// Constants and types for the transmit direction tracker
package idt_pkg;
  // Register map, byte addresses on the Wishbone port
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  // Control register fields
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_EXIT_BIT = 1;
  localparam int CTRL_RELEASE_BIT = 2;
  localparam logic CTRL_ENABLE_RST = 1'b0;
  // Status register fields
  localparam int STAT_TX_BIT = 0;
  localparam int STAT_DRIVE_BIT = 1;
  localparam int STAT_DATA_BIT = 2;
  localparam int STAT_MASTER_BIT = 3;
  localparam int STAT_ENABLE_BIT = 4;
  // Bit positions within the first byte
  localparam logic [3:0] DIR_BIT_IDX = 4'h7;
  localparam logic [3:0] ACK_BIT_IDX = 4'h8;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic TX_FLAG_RST = 1'b0;
  localparam logic OE_N_RST = 1'b1;
  localparam logic SDA_OUT_RST = 1'b1;
  localparam logic [DAT_W-1:0] DAT_ZERO = 32'h0000_0000;
  // Position within a transfer
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_ADDR,
    PH_ACK,
    PH_DATA
  } idt_phase_t;
endpackage : idt_pkg

// File: idt_dir_tracker.sv
// Transmit direction flag of an I2C unit with a Wishbone register port
//
// Decided for this implementation: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module idt_dir_tracker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeN,
  input wire logic shiftOutLatch,
  input wire logic startGenerate,
  input wire logic masterStateFlag,
  input wire logic extensionCodeFlag,
  input wire logic addressMatchFlag,
  input wire logic arbitrationLostFlag,
  output logic txDirectionFlag
);

  // Address decode used by read and write paths
  function automatic logic regHit(input logic [7:0] adr,
                                  input logic [7:0] base);
    regHit = (adr == base);
  endfunction : regHit

  logic ackR;
  logic [31:0] datR;
  logic busUnitEnableR;
  logic busUnitEnablePrevR;
  logic exitCommRequestR;
  logic stretchReleaseR;
  logic wrTake;
  logic sclS1R, sclS2R, sclPrevR;
  logic sdaS1R, sdaS2R, sdaPrevR;
  logic sclRise, sclFall, startDet, stopDet;
  logic [3:0] bitCntR;
  idt_pkg::idt_phase_t phaseR;
  logic dirEvt;
  logic dirBit;
  logic aldPrevR;
  logic aldRise;
  logic enFall;
  logic idleComm;
  logic anyClear;
  logic txFlagR;
  logic txFlagNxt;
  logic sdaOutR;
  logic sdaOeNR;

  // Bus slave: one wait state, ack drops the cycle after it is given
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ackR <= 1'b0;
    end else begin
      ackR <= wb_cyc_i & wb_stb_i & ~ackR;
    end
  end

  assign wrTake = wb_cyc_i & wb_stb_i & wb_we_i & ackR & wb_sel_i[0];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      datR <= idt_pkg::DAT_ZERO;
    end else if (wb_cyc_i & wb_stb_i & ~ackR) begin
      datR <= idt_pkg::DAT_ZERO;
      if (regHit(wb_adr_i, idt_pkg::ADR_CTRL)) begin
        datR[idt_pkg::CTRL_ENABLE_BIT] <= busUnitEnableR;
      end else if (regHit(wb_adr_i, idt_pkg::ADR_STATUS)) begin
        datR[idt_pkg::STAT_TX_BIT] <= txFlagR;
        datR[idt_pkg::STAT_DRIVE_BIT] <= ~sdaOeNR;
        datR[idt_pkg::STAT_DATA_BIT] <= (phaseR == idt_pkg::PH_DATA);
        datR[idt_pkg::STAT_MASTER_BIT] <= masterStateFlag;
        datR[idt_pkg::STAT_ENABLE_BIT] <= busUnitEnableR;
      end
    end
  end

  assign wb_ack_o = ackR;
  assign wb_dat_o = datR;

  // Control register: enable level, exit and release are write-1 pulses
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busUnitEnableR <= idt_pkg::CTRL_ENABLE_RST;
      busUnitEnablePrevR <= idt_pkg::CTRL_ENABLE_RST;
      exitCommRequestR <= 1'b0;
      stretchReleaseR <= 1'b0;
    end else begin
      busUnitEnablePrevR <= busUnitEnableR;
      exitCommRequestR <= 1'b0;
      stretchReleaseR <= 1'b0;
      if (wrTake && regHit(wb_adr_i, idt_pkg::ADR_CTRL)) begin
        busUnitEnableR <= wb_dat_i[idt_pkg::CTRL_ENABLE_BIT];
        exitCommRequestR <= wb_dat_i[idt_pkg::CTRL_EXIT_BIT];
        stretchReleaseR <= wb_dat_i[idt_pkg::CTRL_RELEASE_BIT];
      end
    end
  end

  assign enFall = busUnitEnablePrevR & ~busUnitEnableR;

  // Two-stage synchronisers for the bus lines
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sclS1R <= 1'b1;
      sclS2R <= 1'b1;
      sclPrevR <= 1'b1;
      sdaS1R <= 1'b1;
      sdaS2R <= 1'b1;
      sdaPrevR <= 1'b1;
    end else begin
      sclS1R <= sclIn;
      sclS2R <= sclS1R;
      sclPrevR <= sclS2R;
      sdaS1R <= sdaIn;
      sdaS2R <= sdaS1R;
      sdaPrevR <= sdaS2R;
    end
  end

  assign sclRise = sclS2R & ~sclPrevR;
  assign sclFall = ~sclS2R & sclPrevR;
  assign startDet = sclS2R & sclPrevR & sdaPrevR & ~sdaS2R;
  assign stopDet = sclS2R & sclPrevR & ~sdaPrevR & sdaS2R;

  // Bit counter and phase of the first byte
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phaseR <= idt_pkg::PH_IDLE;
      bitCntR <= idt_pkg::CNT_RST;
    end else if (startDet) begin
      phaseR <= idt_pkg::PH_ADDR;
      bitCntR <= idt_pkg::CNT_RST;
    end else if (stopDet || !busUnitEnableR) begin
      phaseR <= idt_pkg::PH_IDLE;
      bitCntR <= idt_pkg::CNT_RST;
    end else begin
      unique case (phaseR)
        idt_pkg::PH_IDLE: begin
          bitCntR <= idt_pkg::CNT_RST;
        end
        idt_pkg::PH_ADDR: begin
          if (sclRise) begin
            bitCntR <= bitCntR + 4'h1;
            if (bitCntR == idt_pkg::ACK_BIT_IDX) begin
              phaseR <= idt_pkg::PH_ACK;
            end
          end
        end
        idt_pkg::PH_ACK: begin
          if (sclFall) begin
            phaseR <= idt_pkg::PH_DATA;
          end
        end
        idt_pkg::PH_DATA: begin
          bitCntR <= idt_pkg::CNT_RST;
        end
      endcase
    end
  end

  // Direction bit is the eighth bit, taken at its rising clock edge
  assign dirEvt = (phaseR == idt_pkg::PH_ADDR) && sclRise &&
                  (bitCntR == idt_pkg::DIR_BIT_IDX) && !startDet &&
                  !stopDet && busUnitEnableR;
  assign dirBit = sdaS2R;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aldPrevR <= 1'b0;
    end else begin
      aldPrevR <= arbitrationLostFlag;
    end
  end

  assign aldRise = arbitrationLostFlag & ~aldPrevR;
  assign idleComm = !masterStateFlag && !extensionCodeFlag &&
                    !addressMatchFlag && !startGenerate;
  assign anyClear = stopDet | exitCommRequestR | enFall |
                    stretchReleaseR | aldRise | idleComm;

  // Flag update: every cause in anyClear outranks every setting cause
  always_comb begin
    txFlagNxt = txFlagR;
    if (stopDet) begin
      txFlagNxt = 1'b0;
    end else if (exitCommRequestR) begin
      txFlagNxt = 1'b0;
    end else if (enFall) begin
      txFlagNxt = 1'b0;
    end else if (stretchReleaseR) begin
      txFlagNxt = 1'b0;
    end else if (aldRise) begin
      txFlagNxt = 1'b0;
    end else if (idleComm) begin
      txFlagNxt = 1'b0;
    end else if (masterStateFlag || startGenerate) begin
      if (startGenerate) begin
        txFlagNxt = 1'b1;
      end else if (dirEvt) begin
        txFlagNxt = ~dirBit;
      end
    end else begin
      if (startDet) begin
        txFlagNxt = 1'b0;
      end else if (dirEvt) begin
        txFlagNxt = dirBit;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txFlagR <= idt_pkg::TX_FLAG_RST;
    end else begin
      txFlagR <= txFlagNxt;
    end
  end

  assign txDirectionFlag = txFlagR;

  // Data line drive, valid only once the first byte has ended
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sdaOutR <= idt_pkg::SDA_OUT_RST;
      sdaOeNR <= idt_pkg::OE_N_RST;
    end else if (txFlagR && phaseR == idt_pkg::PH_DATA) begin
      sdaOutR <= shiftOutLatch;
      sdaOeNR <= 1'b0;
    end else begin
      sdaOutR <= idt_pkg::SDA_OUT_RST;
      sdaOeNR <= 1'b1;
    end
  end

  assign sdaOut = sdaOutR;
  assign sdaOeN = sdaOeNR;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_dirMaster0;
    masterStateFlag && !startGenerate && dirEvt && !dirBit && !anyClear;
  endsequence

  sequence s_dirSlave1;
    !masterStateFlag && !startGenerate && dirEvt && dirBit && !anyClear;
  endsequence

  sequence s_dirAnyClearing;
    dirEvt && !startGenerate && !anyClear &&
    (masterStateFlag ? dirBit : !dirBit);
  endsequence

  a_reset_flag_low: assert property ($fell(sys_rst) |-> !txFlagR && sdaOeNR)
    else $error("flag or drive not idle after reset");

  a_receive_released: assert property (!txFlagR |=> sdaOeNR [*1] ##1 1'b1)
    else $error("line driven while receiving");

  a_transmit_drives: assert property (
    txFlagR && phaseR == idt_pkg::PH_DATA |=>
    !sdaOeNR && sdaOutR == $past(shiftOutLatch))
    else $error("latch not driven while transmitting");

  a_no_early_drive: assert property (
    phaseR != idt_pkg::PH_DATA |=> sdaOeNR)
    else $error("line driven before first byte ended");

  a_stop_clears: assert property (stopDet |=> !txFlagR)
    else $error("stop did not clear flag");

  a_exit_clears: assert property (exitCommRequestR |=> !txFlagR)
    else $error("exit request did not clear flag");

  a_disable_clears: assert property (
    $fell(busUnitEnableR) |-> ##1 !txFlagR)
    else $error("disable did not clear flag");

  a_release_clears: assert property (
    txFlagR && stretchReleaseR |=> !txFlagR ##1 sdaOeNR)
    else $error("stretch release did not return to receive");

  a_loss_clears: assert property ($rose(arbitrationLostFlag) |=> !txFlagR)
    else $error("arbitration loss did not clear flag");

  a_idle_holds: assert property (idleComm |=> !txFlagR)
    else $error("flag set while not participating");

  a_start_sets: assert property (startGenerate && !anyClear |=> txFlagR)
    else $error("generated start did not set flag");

  a_dir_sets: assert property ((s_dirMaster0 or s_dirSlave1) |=> txFlagR)
    else $error("direction bit did not set flag");

  a_dir_clears: assert property (s_dirAnyClearing |=> !txFlagR)
    else $error("direction bit did not clear flag");

  a_slave_start: assert property (
    startDet && !masterStateFlag && !startGenerate |=> !txFlagR)
    else $error("slave start did not clear flag");

endmodule : idt_dir_tracker
`default_nettype wire

// File: idt_bus_peer.sv
// Behavioural bus peer driving the clock and data lines
`timescale 1ns/100ps
`default_nettype none
module idt_bus_peer (
  output logic sclDrv,
  output logic sdaDrv
);
  localparam realtime HALF = 62.5;
  // A driven 1 means released; the pull-up gives the high level
  initial begin
    sclDrv = 1'b1;
    sdaDrv = 1'b1;
  end
  task automatic startCond();
    sdaDrv = 1'b1;
    #(HALF) sclDrv = 1'b1;
    #(HALF) sdaDrv = 1'b0;
    #(HALF) sclDrv = 1'b0;
  endtask : startCond
  // Eight bits, then the ninth clock with data released
  task automatic sendByte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sdaDrv = b[i];
      #(HALF) sclDrv = 1'b1;
      #(HALF) sclDrv = 1'b0;
    end
    sdaDrv = 1'b1;
    #(HALF) sclDrv = 1'b1;
    #(HALF) sclDrv = 1'b0;
    #(HALF);
  endtask : sendByte
  task automatic stopCond();
    sdaDrv = 1'b0;
    #(HALF) sclDrv = 1'b1;
    #(HALF) sdaDrv = 1'b1;
    #(HALF);
  endtask : stopCond
endmodule : idt_bus_peer
`default_nettype wire

// File: idt_testbench.sv
// Self-checking bench for the transmit direction tracker
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk, sysRst, wbCyc, wbStb, wbWe, wbAck;
  logic [7:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDatW, wbDatR;
  logic sclDrv, sdaDrv, sdaOut, sdaOeN, latch, startGen;
  logic mst, ext, adm, arb, txFlag;
  int fails, checksDone, cycles;
  wire sdaLine = sdaDrv & (sdaOeN | sdaOut);
  idt_dir_tracker idt_dir_tracker_inst (.clk(clk), .sys_rst(sysRst),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
    .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR),
    .wb_ack_o(wbAck), .sclIn(sclDrv), .sdaIn(sdaLine), .sdaOut(sdaOut),
    .sdaOeN(sdaOeN), .shiftOutLatch(latch), .startGenerate(startGen),
    .masterStateFlag(mst), .extensionCodeFlag(ext),
    .addressMatchFlag(adm), .arbitrationLostFlag(arb),
    .txDirectionFlag(txFlag));
  idt_bus_peer idt_bus_peer_inst (.sclDrv(sclDrv), .sdaDrv(sdaDrv));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic test_done();
    $display("checks %0d fails %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  task automatic wbXfer(input logic we, input logic [7:0] adr,
      input logic [31:0] dat, output logic [31:0] rd);
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbSel <= 4'hF;
    wbAdr <= adr;
    wbDatW <= dat;
    // Ends on wbAck; the cycle ceiling ends the run if no ack comes
    do begin
      @(posedge clk);
    end while (wbAck !== 1'b1);
    rd = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask : wbXfer
  task automatic wr(input logic [31:0] d);
    logic [31:0] r;
    wbXfer(1'b1, idt_pkg::ADR_CTRL, d, r);
    settle(4);
  endtask : wr
  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    wbXfer(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask : rdChk
  // Start plus an address byte, then the expected flag
  task automatic setTx(input logic [7:0] b, input logic e);
    idt_bus_peer_inst.startCond();
    idt_bus_peer_inst.sendByte(b);
    settle(10);
    chk({31'h0, txFlag}, {31'h0, e});
  endtask : setTx
  task automatic tReset();
    chk({30'h0, sdaOeN, sdaOut}, 32'h3);
    chk({31'h0, txFlag}, 32'h0);
    rdChk(idt_pkg::ADR_CTRL, 32'h0);
    rdChk(8'h10, 32'h0);
  endtask : tReset
  task automatic tSlave();
    @(posedge clk);
    adm <= 1'b1;
    wr(32'h1);
    setTx(8'hA1, 1'b1);
    chk({30'h0, sdaOeN, sdaOut}, 32'h0);
    @(posedge clk);
    latch <= 1'b1;
    settle(3);
    chk({31'h0, sdaOut}, 32'h1);
    rdChk(idt_pkg::ADR_STATUS, 32'h17);
    idt_bus_peer_inst.stopCond();
    settle(10);
    chk({30'h0, txFlag, sdaOeN}, 32'h1);
  endtask : tSlave
  task automatic tSlaveStart();
    setTx(8'hA1, 1'b1);
    idt_bus_peer_inst.startCond();
    settle(10);
    chk({31'h0, txFlag}, 32'h0);
    idt_bus_peer_inst.sendByte(8'hA0);
    settle(10);
    chk({31'h0, txFlag}, 32'h0);
  endtask : tSlaveStart
  task automatic tRegs();
    setTx(8'hA1, 1'b1);
    wr(32'h3);
    chk({31'h0, txFlag}, 32'h0);
    setTx(8'hA1, 1'b1);
    wr(32'h5);
    chk({30'h0, txFlag, sdaOeN}, 32'h1);
    setTx(8'hA1, 1'b1);
    wr(32'h0);
    chk({31'h0, txFlag}, 32'h0);
    wr(32'h1);
    setTx(8'hA1, 1'b1);
    @(posedge clk);
    ext <= 1'b1;
    adm <= 1'b0;
    settle(4);
    chk({31'h0, txFlag}, 32'h1);
    @(posedge clk);
    ext <= 1'b0;
    settle(4);
    chk({31'h0, txFlag}, 32'h0);
    idt_bus_peer_inst.stopCond();
  endtask : tRegs
  task automatic tMaster();
    @(posedge clk);
    mst <= 1'b1;
    setTx(8'hA0, 1'b1);
    setTx(8'hA1, 1'b0);
    @(posedge clk);
    startGen <= 1'b1;
    @(posedge clk);
    startGen <= 1'b0;
    settle(4);
    chk({31'h0, txFlag}, 32'h1);
    @(posedge clk);
    arb <= 1'b1;
    settle(4);
    chk({31'h0, txFlag}, 32'h0);
    idt_bus_peer_inst.stopCond();
  endtask : tMaster
  // Reset in mid-run while the flag is set
  task automatic tMidReset();
    @(posedge clk);
    arb <= 1'b0;
    startGen <= 1'b1;
    @(posedge clk);
    startGen <= 1'b0;
    settle(4);
    chk({31'h0, txFlag}, 32'h1);
    @(posedge clk);
    sysRst <= 1'b1;
    repeat (3) @(posedge clk);
    sysRst <= 1'b0;
    settle(1);
    chk({29'h0, txFlag, sdaOeN, sdaOut}, 32'h3);
    rdChk(idt_pkg::ADR_CTRL, 32'h0);
  endtask : tMidReset
  initial begin
    {sysRst, wbSel} = 5'h1F;
    {wbCyc, wbStb, wbWe, latch, startGen, mst, ext, adm, arb} = 9'h0;
    {wbAdr, wbDatW} = 40'h0;
    repeat (3) @(posedge clk);
    sysRst <= 1'b0;
    settle(1);
    tReset();
    tSlave();
    tSlaveStart();
    tRegs();
    tMaster();
    tMidReset();
    test_done();
  end
endmodule : testbench
`default_nettype wire
